/* logic/segment_and_io_address_unit.sv */
`timescale 1ns/1ps
module segment_and_io_address_unit #(
	parameter bit WIDE_BUS = 1'b1
) (
	input wire logic sys_clk, // Core clock
	input wire logic reset_n, // Asynchronous reset
	input wire seg_io_pkg::mode_t mode, // Operating mode
	input wire seg_io_pkg::io_req_t io_req, // Port instruction request
	output seg_io_pkg::bus_cycle_t bus_cycle, // External cycle
	output logic io_ack, // Request finished
	output logic io_onchip, // Served on-chip
	output logic [31:0] io_rdata, // On-chip read data
	input wire seg_io_pkg::seg_load_t seg_load, // Selector load
	input wire logic [31:0] global_descriptor_table, // Global base
	input wire logic [31:0] local_descriptor_table, // Local base
	output logic desc_req, // Descriptor fetch
	output logic [31:0] desc_addr, // Descriptor address
	output logic desc_table_local, // Table indicator
	input wire logic desc_valid, // Descriptor returned
	input wire logic [63:0] desc_data, // Descriptor contents
	output logic load_busy, // Load in progress
	output seg_io_pkg::seg_cache_t [5:0] seg_regs, // Segment state
	input wire seg_io_pkg::mem_ref_t mem_ref, // Memory reference
	output logic lin_valid, // Linear address ready
	output logic [31:0] lin_addr, // Linear address
	output seg_io_pkg::seg_id_t lin_seg, // Segment used
	output logic lin_translate, // Needs page tables
	input wire seg_io_pkg::gpr_cmd_t gpr_cmd, // Register update
	output logic [7:0][31:0] gpr_file // General registers
);
	import seg_io_pkg::*;

	typedef struct packed {
		logic [15:0][7:0] cfg;
		logic [3:0] cfg_index;
		logic index_armed;
		logic io_ack;
		logic io_onchip;
		logic [31:0] io_rdata;
		bus_cycle_t bus;
		seg_cache_t [5:0] segs;
		load_state_t load_state;
		seg_id_t load_seg;
		logic [15:0] load_sel;
		logic desc_req;
		logic [31:0] desc_addr;
		logic desc_local;
		logic lin_valid;
		logic [31:0] lin_addr;
		seg_id_t lin_seg;
		logic lin_translate;
		logic [7:0][31:0] gpr;
	} state_t;

	state_t st;
	state_t next_st;

	function automatic logic [31:0] size_bytes(input io_size_t s);
		unique case (s)
			IO_BYTE: size_bytes = 32'h00000001;
			IO_WORD: size_bytes = 32'h00000002;
			IO_DWORD: size_bytes = 32'h00000004;
			default: size_bytes = 32'h00000004;
		endcase
	endfunction

	function automatic logic [31:0] size_mask(input io_size_t s);
		unique case (s)
			IO_BYTE: size_mask = 32'h000000FF;
			IO_WORD: size_mask = 32'h0000FFFF;
			IO_DWORD: size_mask = 32'hFFFFFFFF;
			default: size_mask = 32'hFFFFFFFF;
		endcase
	endfunction

	function automatic logic [31:0] real_base(input logic [15:0] sel);
		real_base = {12'h000, sel, 4'h0};
	endfunction

	function automatic seg_cache_t reset_seg(input logic [15:0] sel);
		reset_seg.sel = sel;
		reset_seg.base = RESET_BASE;
		reset_seg.limit = REAL_LIMIT;
		reset_seg.rights = RESET_RIGHTS;
		reset_seg.priv = 2'h0;
	endfunction

	function automatic logic index_in_range(input logic [7:0] v);
		index_in_range = (v >= CFG_INDEX_LO) && (v <= CFG_INDEX_HI);
	endfunction

	logic is_index_wr;
	logic is_data_acc;
	logic [31:0] desc_base;
	logic [31:0] desc_limit;
	logic [1:0] sel_rpl;
	seg_id_t ref_seg;
	logic [31:0] ref_offset;
	logic [31:0] step;

	always_comb begin
		is_index_wr = io_req.valid && !io_req.float_op && io_req.write
			&& io_req.port == CFG_INDEX_PORT;
		is_data_acc = io_req.valid && !io_req.float_op
			&& io_req.port == CFG_DATA_PORT;
		desc_base = {desc_data[63:56], desc_data[39:16]};
		desc_limit = desc_data[DESC_GRAN_BIT]
			? {desc_data[51:48], desc_data[15:0], 12'hFFF}
			: {12'h000, desc_data[51:48], desc_data[15:0]};
		sel_rpl = st.load_sel[SEL_RPL_LSB +: 2];
		step = size_bytes(gpr_cmd.size);
		// Fixed segments ignore any override prefix
		unique case (mem_ref.kind)
			REF_CODE: ref_seg = SEG_CS;
			REF_STACK: ref_seg = SEG_SS;
			REF_STRING_DST: ref_seg = SEG_ES;
			REF_DATA: begin
				if (mem_ref.override_en)
					ref_seg = mem_ref.override_seg;
				else if (mem_ref.frame_based)
					ref_seg = SEG_SS;
				else
					ref_seg = SEG_DS;
			end
		endcase
		ref_offset = mode.addr32 ? mem_ref.offset
			: {16'h0000, mem_ref.offset[15:0]};
	end

	always_comb begin
		next_st = st;
		next_st.io_ack = 1'b0;
		next_st.io_onchip = 1'b0;
		next_st.bus.start = 1'b0;
		next_st.lin_valid = 1'b0;

		// Port instructions
		if (io_req.valid) begin
			next_st.io_ack = 1'b1;
			next_st.bus.mem_io = 1'b0;
			next_st.bus.write = io_req.write;
			next_st.bus.size = io_req.size;
			next_st.bus.data = io_req.data & size_mask(io_req.size);
			// Only the low 16 bits carry; upper bits stay zero
			next_st.bus.addr = {16'h0000, io_req.port & IO_PORT_MAX};
			if (io_req.float_op) begin
				next_st.bus.start = 1'b1;
				next_st.bus.addr = (WIDE_BUS ? FPU_WINDOW_WIDE
					: FPU_WINDOW_NARROW)
					| {29'h0, io_req.port[FPU_WINDOW_BITS-1:0]};
			end else if (is_index_wr) begin
				if (index_in_range(io_req.data[7:0])) begin
					next_st.io_onchip = 1'b1;
					next_st.cfg_index = io_req.data[3:0];
					next_st.index_armed = 1'b1;
				end else begin
					next_st.bus.start = 1'b1;
					next_st.index_armed = 1'b0;
				end
			end else if (is_data_acc && st.index_armed) begin
				// One data access consumes the index
				next_st.io_onchip = 1'b1;
				next_st.index_armed = 1'b0;
				if (io_req.write)
					next_st.cfg[st.cfg_index] = io_req.data[7:0];
				else
					next_st.io_rdata = {24'h000000, st.cfg[st.cfg_index]};
			end else begin
				// Index reads and stale data accesses go off-chip
				next_st.bus.start = 1'b1;
			end
		end

		// Segment register loads
		unique case (st.load_state)
			LD_IDLE: begin
				if (seg_load.valid) begin
					if (!mode.prot || mode.virt_real) begin
						next_st.segs[seg_load.seg].sel = seg_load.sel;
						next_st.segs[seg_load.seg].base
							= real_base(seg_load.sel);
						next_st.segs[seg_load.seg].limit = REAL_LIMIT;
					end else begin
						next_st.load_state = LD_WAIT;
						next_st.load_seg = seg_load.seg;
						next_st.load_sel = seg_load.sel;
						next_st.desc_req = 1'b1;
						next_st.desc_local = seg_load.sel[SEL_TI_BIT];
						next_st.desc_addr = (seg_load.sel[SEL_TI_BIT]
							? local_descriptor_table
							: global_descriptor_table)
							+ {16'h0000,
							seg_load.sel[15:SEL_INDEX_LSB],
							3'h0};
					end
				end
			end
			LD_WAIT: begin
				if (desc_valid) begin
					next_st.load_state = LD_IDLE;
					next_st.desc_req = 1'b0;
					next_st.segs[st.load_seg].sel = st.load_sel;
					next_st.segs[st.load_seg].base = desc_base;
					next_st.segs[st.load_seg].limit = desc_limit;
					next_st.segs[st.load_seg].rights = desc_data[47:40];
					next_st.segs[st.load_seg].priv
						= (sel_rpl > mode.current_privilege)
						? sel_rpl : mode.current_privilege;
				end
			end
		endcase

		// Linear address formation from the cached base
		if (mem_ref.valid) begin
			next_st.lin_valid = 1'b1;
			next_st.lin_seg = ref_seg;
			next_st.lin_addr = st.segs[ref_seg].base + ref_offset;
			next_st.lin_translate = mode.paging && mode.prot;
		end

		// General register updates
		unique case (gpr_cmd.op)
			GPR_NONE: begin
			end
			GPR_WRITE: begin
				unique case (gpr_cmd.size)
					IO_BYTE: begin
						if (gpr_cmd.high_byte)
							next_st.gpr[gpr_cmd.id][15:8]
								= gpr_cmd.data[7:0];
						else
							next_st.gpr[gpr_cmd.id][7:0]
								= gpr_cmd.data[7:0];
					end
					IO_WORD: next_st.gpr[gpr_cmd.id][15:0]
						= gpr_cmd.data[15:0];
					default: next_st.gpr[gpr_cmd.id] = gpr_cmd.data;
				endcase
			end
			GPR_STRING: begin
				if (gpr_cmd.dec) begin
					next_st.gpr[SRC_INDEX_REG] = st.gpr[SRC_INDEX_REG] - step;
					next_st.gpr[DST_INDEX_REG] = st.gpr[DST_INDEX_REG] - step;
				end else begin
					next_st.gpr[SRC_INDEX_REG] = st.gpr[SRC_INDEX_REG] + step;
					next_st.gpr[DST_INDEX_REG] = st.gpr[DST_INDEX_REG] + step;
				end
				if (gpr_cmd.rep)
					next_st.gpr[COUNT_REG] = st.gpr[COUNT_REG] - 32'h00000001;
			end
			GPR_PUSH: next_st.gpr[STACK_POINTER_REG]
				= st.gpr[STACK_POINTER_REG] - step;
			GPR_POP: next_st.gpr[STACK_POINTER_REG]
				= st.gpr[STACK_POINTER_REG] + step;
			default: begin
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
			st.bus.mem_io <= 1'b1;
			// Six segment caches reset to a 64K real-mode window
			for (int i = 0; i < 6; i++) begin
				st.segs[i] <= reset_seg(RESET_SEL);
			end
			st.segs[SEG_CS] <= reset_seg(RESET_CODE_SEL);
		end else begin
			st <= next_st;
		end
	end

	assign bus_cycle = st.bus;
	assign io_ack = st.io_ack;
	assign io_onchip = st.io_onchip;
	assign io_rdata = st.io_rdata;
	assign desc_req = st.desc_req;
	assign desc_addr = st.desc_addr;
	assign desc_table_local = st.desc_local;
	assign load_busy = st.load_state == LD_WAIT;
	assign seg_regs = st.segs;
	assign lin_valid = st.lin_valid;
	assign lin_addr = st.lin_addr;
	assign lin_seg = st.lin_seg;
	assign lin_translate = st.lin_translate;
	assign gpr_file = st.gpr;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	sequence seq_index_ok;
		is_index_wr && index_in_range(io_req.data[7:0]);
	endsequence

	sequence seq_data_acc;
		is_data_acc;
	endsequence

	a_io_select_low: assert property (bus_cycle.start |-> !bus_cycle.mem_io)
		else $error("port cycle with memory select high");

	a_upper_addr_zero: assert property (
		io_req.valid && !io_req.float_op |=>
		bus_cycle.addr[31:16] == 16'h0000)
		else $error("upper address bits not low on port cycle");

	a_fpu_window: assert property (
		io_req.valid && io_req.float_op |=> bus_cycle.start
		&& bus_cycle.addr[31:3] == (WIDE_BUS ? FPU_WINDOW_WIDE[31:3]
		: FPU_WINDOW_NARROW[31:3]))
		else $error("coprocessor access outside its window");

	a_index_read_out: assert property (
		io_req.valid && !io_req.float_op && !io_req.write
		&& io_req.port == CFG_INDEX_PORT |=> bus_cycle.start && !io_onchip)
		else $error("index port read kept on-chip");

	a_bad_index_out: assert property (
		is_index_wr && !index_in_range(io_req.data[7:0])
		|=> bus_cycle.start && $stable(st.cfg) && !st.index_armed)
		else $error("bad index altered configuration");

	a_data_after_index: assert property (
		seq_index_ok ##1 !io_req.valid ##1 seq_data_acc
		|=> io_onchip && !bus_cycle.start)
		else $error("indexed data access went off-chip");

	a_stale_data_out: assert property (
		seq_index_ok ##1 !io_req.valid ##1 seq_data_acc
		##1 !io_req.valid ##1 seq_data_acc
		|=> bus_cycle.start && $stable(st.cfg))
		else $error("second data access stayed on-chip");

	a_byte_keeps_upper: assert property (
		gpr_cmd.op == GPR_WRITE && gpr_cmd.size == IO_BYTE
		&& !gpr_cmd.high_byte |=>
		gpr_file[$past(gpr_cmd.id)][31:8]
		== $past(gpr_file[gpr_cmd.id][31:8]))
		else $error("byte write disturbed upper bytes");

	a_push_adjust: assert property (
		gpr_cmd.op == GPR_PUSH && gpr_cmd.size == IO_DWORD |=>
		gpr_file[STACK_POINTER_REG]
		== $past(gpr_file[STACK_POINTER_REG]) - 32'h00000004)
		else $error("stack pointer not lowered by four");

	a_real_base: assert property (
		st.load_state == LD_IDLE && seg_load.valid
		&& (!mode.prot || mode.virt_real) |=>
		seg_regs[$past(seg_load.seg)].base
		== {12'h000, $past(seg_load.sel), 4'h0})
		else $error("real-mode base not selector times 16");

	a_effective_priv: assert property (
		st.load_state == LD_WAIT && desc_valid |=>
		seg_regs[$past(st.load_seg)].priv >= $past(mode.current_privilege)
		&& seg_regs[$past(st.load_seg)].priv >= $past(sel_rpl))
		else $error("effective privilege too privileged");

	a_no_refetch: assert property (
		st.load_state == LD_IDLE && !seg_load.valid |=> !desc_req)
		else $error("descriptor fetched without a load");

	a_fixed_code_seg: assert property (
		mem_ref.valid && mem_ref.kind == REF_CODE |=> lin_valid
		&& lin_seg == SEG_CS)
		else $error("code fetch not from code segment");

endmodule

/* logic/seg_io_pkg.sv */
// Function
// - Port space limited to 64K from zero
// - Float escape reaches coprocessor window automatically
// - Port transfers of byte, word, doubleword
// - Port cycles drive memory-or-io select low
// - Upper address bits low during port cycles, except coprocessor cycles
// - Index to 0x22, data via 0x23, no bus
// - Data access needs fresh index, else external
// - Index outside C0..CF goes external, no change
// - Index port reads always go off-chip
// - Narrow register writes keep upper bytes
// - Strings use source, destination, count registers
// - Stack pointer adjusts on stack operations
// - Six 16-bit segment registers
// - Real mode linear is segment*16 plus offset; code segment base stays 0 from reset until it is loaded
// - Linear is physical unless paging translates it
// - Selector is index, table bit, privilege
// - Index picks one of 8192 eight-byte descriptors
// - Table bit 0 global, 1 local
// - Effective privilege is less privileged of two
// - Descriptor cached on load, no refetch
// - Code, stack, string-store segments not overridable
// - Data defaults by base register, overridable
package seg_io_pkg;

	localparam logic [15:0] IO_PORT_MAX = 16'hFFFF;
	localparam logic [15:0] CFG_INDEX_PORT = 16'h0022;
	localparam logic [15:0] CFG_DATA_PORT = 16'h0023;
	localparam logic [7:0] CFG_INDEX_LO = 8'hC0;
	localparam logic [7:0] CFG_INDEX_HI = 8'hCF;
	localparam logic [31:0] FPU_WINDOW_NARROW = 32'h008000F8;
	localparam logic [31:0] FPU_WINDOW_WIDE = 32'h800000F8;
	localparam int FPU_WINDOW_BITS = 3;

	localparam int SEL_RPL_LSB = 0;
	localparam int SEL_TI_BIT = 2;
	localparam int SEL_INDEX_LSB = 3;
	localparam int DESC_SIZE_SHIFT = 3;
	localparam int DESC_GRAN_BIT = 55;
	localparam logic [15:0] RESET_CODE_SEL = 16'hF000;
	localparam logic [15:0] RESET_SEL = 16'h0000;
	localparam logic [31:0] RESET_BASE = 32'h00000000;
	localparam logic [31:0] REAL_LIMIT = 32'h0000FFFF;
	localparam logic [7:0] RESET_RIGHTS = 8'h93;

	typedef enum logic [2:0] {
		SEG_ES = 3'b000,
		SEG_CS = 3'b001,
		SEG_SS = 3'b010,
		SEG_DS = 3'b011,
		SEG_FS = 3'b100,
		SEG_GS = 3'b101
	} seg_id_t;

	typedef enum logic [1:0] {
		IO_BYTE = 2'b00,
		IO_WORD = 2'b01,
		IO_DWORD = 2'b10
	} io_size_t;

	typedef enum logic [1:0] {
		REF_CODE = 2'b00,
		REF_STACK = 2'b01,
		REF_STRING_DST = 2'b10,
		REF_DATA = 2'b11
	} ref_kind_t;

	typedef enum logic [2:0] {
		GPR_NONE = 3'b000,
		GPR_WRITE = 3'b001,
		GPR_STRING = 3'b010,
		GPR_PUSH = 3'b011,
		GPR_POP = 3'b100
	} gpr_op_t;

	typedef enum logic {
		LD_IDLE = 1'b0,
		LD_WAIT = 1'b1
	} load_state_t;

	localparam logic [2:0] COUNT_REG = 3'd1;
	localparam logic [2:0] STACK_POINTER_REG = 3'd4;
	localparam logic [2:0] SRC_INDEX_REG = 3'd6;
	localparam logic [2:0] DST_INDEX_REG = 3'd7;

	typedef struct packed {
		logic valid;
		logic write;
		logic float_op;
		io_size_t size;
		logic [15:0] port;
		logic [31:0] data;
	} io_req_t;

	typedef struct packed {
		logic start;
		logic mem_io;
		logic write;
		io_size_t size;
		logic [31:0] addr;
		logic [31:0] data;
	} bus_cycle_t;

	typedef struct packed {
		logic [15:0] sel;
		logic [31:0] base;
		logic [31:0] limit;
		logic [7:0] rights;
		logic [1:0] priv;
	} seg_cache_t;

	typedef struct packed {
		logic valid;
		seg_id_t seg;
		logic [15:0] sel;
	} seg_load_t;

	typedef struct packed {
		logic valid;
		ref_kind_t kind;
		logic frame_based;
		logic override_en;
		seg_id_t override_seg;
		logic [31:0] offset;
	} mem_ref_t;

	typedef struct packed {
		gpr_op_t op;
		logic [2:0] id;
		io_size_t size;
		logic high_byte;
		logic dec;
		logic rep;
		logic [31:0] data;
	} gpr_cmd_t;

	typedef struct packed {
		logic paging;
		logic prot;
		logic virt_real;
		logic addr32;
		logic [1:0] current_privilege;
	} mode_t;

endpackage

/* test/desc_table_model.sv */
`timescale 1ns/1ps
module desc_table_model (
	input wire logic sys_clk, // Core clock
	input wire logic reset_n, // Asynchronous reset
	input wire logic [3:0] resp_delay, // Cycles before answer
	input wire logic desc_req, // Fetch request
	input wire logic [31:0] desc_addr, // Descriptor address
	output logic desc_valid, // Answer strobe
	output logic [63:0] desc_data // Descriptor contents
);
	logic [3:0] waited;
	logic [63:0] last;
	// Base follows the low 16 address bits so a fetch address wrong in those bits shows up in the base
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			waited <= 4'h0;
			desc_valid <= 1'b0;
			desc_data <= 64'h0;
			last <= 64'h0;
		end else if (desc_req && !desc_valid && waited >= resp_delay) begin
			desc_valid <= 1'b1;
			desc_data <= {16'h1200, 8'h92, 8'h00, desc_addr[15:0], 16'hABCD};
			last <= {16'h1200, 8'h92, 8'h00, desc_addr[15:0], 16'hABCD};
			waited <= 4'h0;
		end else begin
			desc_valid <= 1'b0;
			// Outside a reply the lines never repeat the last descriptor
			desc_data <= ~last;
			if (desc_req && !desc_valid) begin
				waited <= waited + 4'h1;
			end
		end
	end
endmodule

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import seg_io_pkg::*;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	mode_t mode = '0;
	io_req_t io_req = '0;
	seg_load_t seg_load = '0;
	mem_ref_t mem_ref = '0;
	gpr_cmd_t gpr_cmd = '0;
	logic [31:0] glob_base = 32'h00010000;
	logic [31:0] loc_base = 32'h00020000;
	logic [3:0] resp_delay = 4'h3;
	bus_cycle_t bus_cycle;
	logic io_ack, io_onchip, desc_req, desc_table_local, desc_valid;
	logic load_busy, lin_valid, lin_translate;
	logic [31:0] io_rdata, desc_addr, lin_addr;
	logic [63:0] desc_data;
	seg_cache_t [5:0] seg_regs;
	seg_id_t lin_seg;
	logic [7:0][31:0] gpr_file;
	int failures = 0;
	int n_tests = 0;

	always #4 sys_clk = ~sys_clk;

	segment_and_io_address_unit segment_and_io_address_unit_inst (
		.sys_clk(sys_clk), .reset_n(reset_n), .mode(mode), .io_req(io_req),
		.bus_cycle(bus_cycle), .io_ack(io_ack), .io_onchip(io_onchip),
		.io_rdata(io_rdata), .seg_load(seg_load),
		.global_descriptor_table(glob_base),
		.local_descriptor_table(loc_base), .desc_req(desc_req),
		.desc_addr(desc_addr), .desc_table_local(desc_table_local),
		.desc_valid(desc_valid), .desc_data(desc_data),
		.load_busy(load_busy), .seg_regs(seg_regs), .mem_ref(mem_ref),
		.lin_valid(lin_valid), .lin_addr(lin_addr), .lin_seg(lin_seg),
		.lin_translate(lin_translate), .gpr_cmd(gpr_cmd),
		.gpr_file(gpr_file));

	desc_table_model desc_table_model_inst (
		.sys_clk(sys_clk), .reset_n(reset_n), .resp_delay(resp_delay),
		.desc_req(desc_req), .desc_addr(desc_addr),
		.desc_valid(desc_valid), .desc_data(desc_data));

	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic port_op(input logic wr, input logic fl, input io_size_t sz,
			input logic [15:0] port, input logic [31:0] d, input logic onchip);
		@(posedge sys_clk);
		io_req <= '{valid: 1'b1, write: wr, float_op: fl, size: sz, port: port,
			data: d};
		@(posedge sys_clk);
		io_req.valid <= 1'b0;
		#1;
		chk("io_ack", 32'h1, io_ack);
		chk("io_onchip", onchip, io_onchip);
		chk("bus start", !onchip, bus_cycle.start);
	endtask

	task automatic t_config();
		port_op(1, 0, IO_BYTE, 16'h0022, 32'hC3, 1);
		port_op(1, 0, IO_BYTE, 16'h0023, 32'h5A, 1);
		port_op(0, 0, IO_BYTE, 16'h0023, 32'h0, 0);
		chk("stale addr", 32'h23, bus_cycle.addr);
		port_op(1, 0, IO_BYTE, 16'h0022, 32'hC3, 1);
		port_op(0, 0, IO_BYTE, 16'h0023, 32'h0, 1);
		chk("cfg read", 32'h5A, io_rdata);
		port_op(1, 0, IO_BYTE, 16'h0022, 32'hCF, 1);
		port_op(1, 0, IO_BYTE, 16'h0022, 32'hBF, 0);
		port_op(1, 0, IO_BYTE, 16'h0023, 32'h11, 0);
		port_op(1, 0, IO_BYTE, 16'h0022, 32'hD0, 0);
		port_op(1, 0, IO_BYTE, 16'h0022, 32'hC3, 1);
		port_op(0, 0, IO_BYTE, 16'h0023, 32'h0, 1);
		chk("cfg kept", 32'h5A, io_rdata);
		port_op(0, 0, IO_BYTE, 16'h0022, 32'h0, 0);
		chk("index read addr", 32'h22, bus_cycle.addr);
	endtask

	task automatic t_ports();
		io_size_t sz[3] = '{IO_BYTE, IO_WORD, IO_DWORD};
		logic [31:0] dm[3] = '{32'h34, 32'h1234, 32'hCAFE1234};
		for (int i = 0; i < 3; i++) begin
			port_op(1, 0, sz[i], 16'hFFFF, 32'hCAFE1234, 0);
			chk("port addr", 32'h0000FFFF, bus_cycle.addr);
			chk("mem_io", 32'h0, bus_cycle.mem_io);
			chk("size", sz[i], bus_cycle.size);
			chk("data", dm[i], bus_cycle.data);
		end
		port_op(0, 1, IO_WORD, 16'h0005, 32'h0, 0);
		chk("float addr", 32'h800000FD, bus_cycle.addr);
		chk("float mem_io", 32'h0, bus_cycle.mem_io);
	endtask

	task automatic gpr_do(input gpr_op_t op, input logic [2:0] id,
			input io_size_t sz, input logic hb, input logic [31:0] d);
		@(posedge sys_clk);
		gpr_cmd <= '{op: op, id: id, size: sz, high_byte: hb, dec: 1'b0,
			rep: 1'b1, data: d};
		@(posedge sys_clk);
		gpr_cmd.op <= GPR_NONE;
		#1;
	endtask

	task automatic t_gpr();
		gpr_do(GPR_WRITE, 3'd3, IO_DWORD, 0, 32'h11223344);
		gpr_do(GPR_WRITE, 3'd3, IO_BYTE, 1, 32'h0000ABAB);
		chk("high byte", 32'h1122AB44, gpr_file[3]);
		gpr_do(GPR_WRITE, 3'd3, IO_WORD, 0, 32'h00005566);
		chk("word", 32'h11225566, gpr_file[3]);
		gpr_do(GPR_WRITE, STACK_POINTER_REG, IO_DWORD, 0, 32'h1000);
		gpr_do(GPR_PUSH, STACK_POINTER_REG, IO_DWORD, 0, 32'h0);
		chk("push", 32'h0FFC, gpr_file[4]);
		gpr_do(GPR_POP, STACK_POINTER_REG, IO_WORD, 0, 32'h0);
		chk("pop", 32'h0FFE, gpr_file[4]);
		gpr_do(GPR_WRITE, SRC_INDEX_REG, IO_DWORD, 0, 32'h100);
		gpr_do(GPR_WRITE, DST_INDEX_REG, IO_DWORD, 0, 32'h200);
		gpr_do(GPR_WRITE, COUNT_REG, IO_DWORD, 0, 32'h5);
		gpr_do(GPR_STRING, 3'd0, IO_DWORD, 0, 32'h0);
		chk("src", 32'h104, gpr_file[6]);
		chk("dst", 32'h204, gpr_file[7]);
		chk("count", 32'h4, gpr_file[1]);
	endtask

	task automatic seg_do(input seg_id_t s, input logic [15:0] sel);
		@(posedge sys_clk);
		seg_load <= '{valid: 1'b1, seg: s, sel: sel};
		@(posedge sys_clk);
		seg_load.valid <= 1'b0;
		#1;
	endtask

	task automatic ref_do(input ref_kind_t k, input logic fb, input logic ov,
			input seg_id_t os, input seg_id_t es, input logic [31:0] el);
		@(posedge sys_clk);
		mem_ref <= '{valid: 1'b1, kind: k, frame_based: fb, override_en: ov,
			override_seg: os, offset: 32'h00010005};
		@(posedge sys_clk);
		mem_ref.valid <= 1'b0;
		#1;
		chk("lin_valid", 32'h1, lin_valid);
		chk("lin_seg", es, lin_seg);
		chk("lin_addr", el, lin_addr);
		chk("translate", mode.paging && mode.prot, lin_translate);
	endtask

	task automatic t_real();
		seg_do(SEG_DS, 16'h1234);
		chk("real base", 32'h00012340, seg_regs[SEG_DS].base);
		seg_do(SEG_SS, 16'h2000);
		seg_do(SEG_ES, 16'h3000);
		seg_do(SEG_FS, 16'h4000);
		ref_do(REF_DATA, 0, 0, SEG_CS, SEG_DS, 32'h00012345);
		ref_do(REF_DATA, 1, 0, SEG_CS, SEG_SS, 32'h00020005);
		ref_do(REF_DATA, 0, 1, SEG_FS, SEG_FS, 32'h00040005);
		ref_do(REF_STACK, 0, 1, SEG_DS, SEG_SS, 32'h00020005);
		ref_do(REF_STRING_DST, 0, 1, SEG_FS, SEG_ES, 32'h00030005);
		ref_do(REF_CODE, 0, 1, SEG_DS, SEG_CS, 32'h00000005);
		mode.addr32 <= 1'b1;
		ref_do(REF_DATA, 0, 0, SEG_CS, SEG_DS, 32'h00022345);
	endtask

	task automatic prot_load(input seg_id_t s, input logic [15:0] sel,
			input logic [31:0] ea, input logic loc, input logic [1:0] pr);
		int n;
		seg_do(s, sel);
		chk("desc_req", 32'h1, desc_req);
		chk("desc_addr", ea, desc_addr);
		chk("table", loc, desc_table_local);
		n = 0;
		while (load_busy !== 1'b0 && n < 20) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (load_busy !== 1'b0) begin
			failures++;
			$display("[FAIL] load wait expected idle seen busy");
			return;
		end
		chk("prot base", {16'h1200, ea[15:0]}, seg_regs[s].base);
		chk("rights", 32'h92, seg_regs[s].rights);
		chk("priv", pr, seg_regs[s].priv);
		chk("sel", sel, seg_regs[s].sel);
	endtask

	task automatic t_prot();
		mode <= '{paging: 1'b1, prot: 1'b1, virt_real: 1'b0, addr32: 1'b1,
			current_privilege: 2'd1};
		prot_load(SEG_DS, 16'h000F, 32'h00020008, 1, 2'd3);
		resp_delay <= 4'h0;
		prot_load(SEG_ES, 16'h0010, 32'h00010010, 0, 2'd1);
		ref_do(REF_DATA, 0, 0, SEG_CS, SEG_DS, 32'h1201000D);
		chk("no refetch", 32'h0, desc_req);
	endtask

	initial begin
		repeat (6) @(posedge sys_clk);
		#1;
		chk("reset mem_io", 32'h1, bus_cycle.mem_io);
		chk("reset code sel", 32'hF000, seg_regs[SEG_CS].sel);
		chk("reset limit", 32'h0000FFFF, seg_regs[SEG_DS].limit);
		@(posedge sys_clk);
		reset_n <= 1'b1;
		t_config();
		t_ports();
		t_gpr();
		t_real();
		t_prot();
		repeat (2) @(posedge sys_clk);
		give_verdict();
	end
endmodule
